/* File: common/tag_area_pkg.sv */
// constants, commands and state types for the tag memory area policy block
package tag_area_pkg;

	// user area geometry
	localparam int BLOCK_BITS      = 8;
	localparam int WORD_BITS       = 4;
	localparam int DATA_BITS       = 16;
	localparam int MEM_ADDR_BITS   = BLOCK_BITS + WORD_BITS;
	localparam int BLOCK_COUNT     = 256;
	localparam int CODE_BITS       = 8;
	localparam int UID_BITS        = 64;
	localparam int UID_WORDS       = UID_BITS / DATA_BITS;

	// every block number from first to last is user area
	localparam logic [BLOCK_BITS-1:0] USER_FIRST_BLOCK = 8'h00;
	localparam logic [BLOCK_BITS-1:0] USER_LAST_BLOCK  = 8'hFF;

	// factory values of the rewritable identifiers
	localparam logic [CODE_BITS-1:0] AFC_RESET = 8'h00;
	localparam logic [CODE_BITS-1:0] SFC_RESET = 8'h00;

	// fixed tag identifier; value is arbitrary
	localparam logic [UID_BITS-1:0] UID_VALUE = 64'h0123_4567_89AB_CDEF;

	// system item selectors, carried on the word field of a system read
	localparam logic [WORD_BITS-1:0] SYS_UID_W0     = 4'h0;
	localparam logic [WORD_BITS-1:0] SYS_UID_W3     = 4'h3;
	localparam logic [WORD_BITS-1:0] SYS_AFC        = 4'h4;
	localparam logic [WORD_BITS-1:0] SYS_SFC        = 4'h5;
	localparam logic [WORD_BITS-1:0] SYS_BLOCK_LOCK = 4'h6;
	localparam logic [WORD_BITS-1:0] SYS_CODE_LOCKS = 4'h7;

	// bit positions in the identifier lock status word
	localparam int AFC_LOCK_BIT = 0;
	localparam int SFC_LOCK_BIT = 1;

	// commands
	typedef enum logic [3:0] {
		OP_READ_WORD   = 4'h0,
		OP_WRITE_WORD  = 4'h1,
		OP_LOCK_BLOCK  = 4'h2,
		OP_READ_SYSTEM = 4'h3,
		OP_WRITE_AFC   = 4'h4,
		OP_WRITE_SFC   = 4'h5,
		OP_LOCK_AFC    = 4'h6,
		OP_LOCK_SFC    = 4'h7,
		OP_WRITE_UID   = 4'h8
	} op_t;

	// sequencer states
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_READ_WAIT
	} state_t;

endpackage

/* File: logic/tag_word_store.sv */
// user area word store with registered read data
`timescale 1ns/100ps
`default_nettype none
module tag_word_store
	import tag_area_pkg::*;
(
	// clock and reset
	input  wire logic                     clock,
	input  wire logic                     rst,
	// access port
	input  wire logic                     write_en,
	input  wire logic                     read_en,
	input  wire logic [MEM_ADDR_BITS-1:0] addr,
	input  wire logic [DATA_BITS-1:0]     write_data,
	output logic      [DATA_BITS-1:0]     read_data
);

	// array has no reset, as nonvolatile contents would not clear
	logic [DATA_BITS-1:0] cells [0:(1 << MEM_ADDR_BITS)-1];

	always_ff @(posedge clock) begin
		if (write_en) begin
			cells[addr] <= write_data;
		end
	end

	// read data held until the next read
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			read_data <= '0;
		end else if (read_en) begin
			read_data <= cells[addr];
		end
	end

endmodule // tag_word_store
`default_nettype wire

/* File: logic/tag_area_policy.sv */
// access policy for the tag user area and system area
`timescale 1ns/100ps
`default_nettype none
// Function
// R1: block numbers 00H to FFH are user area
// R2: system area only through dedicated commands
// R3: system area holds identifiers and block locks
// R4: tag identifier fixed, writes to it refused
// R5: both codes rewritable, lockable, then refused
// R6: word address upward selects higher block slices
module tag_area_policy
	import tag_area_pkg::*;
(
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst,
	// request
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire op_t                   req_op,
	input  wire logic [BLOCK_BITS-1:0] req_block,
	input  wire logic [WORD_BITS-1:0]  req_word,
	input  wire logic [DATA_BITS-1:0]  req_data,
	// answer
	output logic                       rsp_valid,
	output logic                       rsp_ok,
	output logic      [DATA_BITS-1:0]  rsp_data
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		state_t                 state;
		logic [CODE_BITS-1:0]   afc;
		logic [CODE_BITS-1:0]   sfc;
		logic                   afc_locked;
		logic                   sfc_locked;
		logic [BLOCK_COUNT-1:0] block_locked;
		logic                   rsp_valid;
		logic                   rsp_ok;
		logic [DATA_BITS-1:0]   rsp_data;
	} policy_t;

	policy_t                  s;
	policy_t                  next_s;
	logic                     mem_we;
	logic                     mem_re;
	logic [MEM_ADDR_BITS-1:0] mem_addr;
	logic [DATA_BITS-1:0]     mem_rdata;
	logic                     take;
	logic [UID_BITS-1:0]      unique_tag_identifier;

	assign unique_tag_identifier = UID_VALUE; // [R4]
	assign take = req_valid && req_ready;

	// one request at a time; a read holds the port for its wait cycle
	assign req_ready = (s.state == ST_IDLE);
	assign rsp_valid = s.rsp_valid;
	assign rsp_ok    = s.rsp_ok;
	assign rsp_data  = s.rsp_data;

	// word index sits below block number, so word w is bits 16w+15..16w
	assign mem_addr = {req_block, req_word}; // [R1] [R6]

	////////////////////////////////////////////////////////////////////////////////
	// storage

	tag_word_store u_store (
		.clock      (clock),
		.rst        (rst),
		.write_en   (mem_we),
		.read_en    (mem_re),
		.addr       (mem_addr),
		.write_data (req_data),
		.read_data  (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// command decode

	// answers are one-cycle pulses; refusals still answer, with ok low
	always_comb begin
		next_s           = s;
		next_s.rsp_valid = 1'b0;
		mem_we           = 1'b0;
		mem_re           = 1'b0;
		case (s.state)
			ST_IDLE: begin
				if (req_valid) begin
					next_s.rsp_valid = 1'b1;
					next_s.rsp_ok    = 1'b1;
					next_s.rsp_data  = '0;
					case (req_op)
						OP_READ_WORD: begin
							// any block number is user area, no range check needed
							mem_re           = 1'b1; // [R1]
							next_s.rsp_valid = 1'b0;
							next_s.state     = ST_READ_WAIT;
						end
						OP_WRITE_WORD: begin
							if (s.block_locked[req_block]) begin
								next_s.rsp_ok = 1'b0; // [R3]
							end else begin
								mem_we = 1'b1; // [R1]
							end
						end
						OP_LOCK_BLOCK: begin
							next_s.block_locked[req_block] = 1'b1; // [R3]
						end
						OP_READ_SYSTEM: begin
							// system items only reachable here, never by block number
							case (req_word) // [R2]
								SYS_AFC: begin
									next_s.rsp_data = {{(DATA_BITS-CODE_BITS){1'b0}}, s.afc}; // [R3]
								end
								SYS_SFC: begin
									next_s.rsp_data = {{(DATA_BITS-CODE_BITS){1'b0}}, s.sfc}; // [R3]
								end
								SYS_BLOCK_LOCK: begin
									next_s.rsp_data = {{(DATA_BITS-1){1'b0}},
										s.block_locked[req_block]}; // [R3]
								end
								SYS_CODE_LOCKS: begin
									next_s.rsp_data = '0;
									next_s.rsp_data[AFC_LOCK_BIT] = s.afc_locked;
									next_s.rsp_data[SFC_LOCK_BIT] = s.sfc_locked;
								end
								default: begin
									if (req_word <= SYS_UID_W3) begin
										next_s.rsp_data = unique_tag_identifier[req_word[1:0]*DATA_BITS +: DATA_BITS]; // [R3]
									end else begin
										next_s.rsp_ok = 1'b0;
									end
								end
							endcase
						end
						OP_WRITE_AFC: begin
							if (s.afc_locked) begin
								next_s.rsp_ok = 1'b0; // [R5]
							end else begin
								next_s.afc = req_data[CODE_BITS-1:0]; // [R5]
							end
						end
						OP_WRITE_SFC: begin
							if (s.sfc_locked) begin
								next_s.rsp_ok = 1'b0; // [R5]
							end else begin
								next_s.sfc = req_data[CODE_BITS-1:0]; // [R5]
							end
						end
						OP_LOCK_AFC: begin
							next_s.afc_locked = 1'b1; // [R5]
						end
						OP_LOCK_SFC: begin
							next_s.sfc_locked = 1'b1; // [R5]
						end
						OP_WRITE_UID: begin
							next_s.rsp_ok = 1'b0; // [R4]
						end
						default: begin
							next_s.rsp_ok = 1'b0;
						end
					endcase
				end
			end
			ST_READ_WAIT: begin
				// store read data registered one cycle after the request
				next_s.rsp_valid = 1'b1;
				next_s.rsp_ok    = 1'b1;
				next_s.rsp_data  = mem_rdata; // [R6]
				next_s.state     = ST_IDLE;
			end
			default: begin
				next_s.state = ST_IDLE;
			end
		endcase
	end

	// locks reset to open; a real part would keep them through power loss
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s              <= '0;
			s.state        <= ST_IDLE;
			s.afc          <= AFC_RESET;
			s.sfc          <= SFC_RESET;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_user_read;
		@(posedge clock) disable iff (rst)
		take && req_op == OP_READ_WORD |=> !rsp_valid && !req_ready ##1 rsp_valid && rsp_ok;
	endproperty
	a_user_read: assert property (p_user_read) else $error("user read answer late"); // [R1]

	property p_store_only_user;
		@(posedge clock) disable iff (rst)
		(mem_we || mem_re) |-> take && (req_op == OP_READ_WORD || req_op == OP_WRITE_WORD);
	endproperty
	a_store_only_user: assert property (p_store_only_user)
		else $error("store reached by system command"); // [R2]

	property p_locked_block;
		@(posedge clock) disable iff (rst)
		take && req_op == OP_WRITE_WORD && s.block_locked[req_block]
			|-> !mem_we ##1 rsp_valid && !rsp_ok;
	endproperty
	a_locked_block: assert property (p_locked_block) else $error("locked block written"); // [R3]

	property p_uid_read;
		@(posedge clock) disable iff (rst)
		take && req_op == OP_READ_SYSTEM && req_word <= SYS_UID_W3
			|=> rsp_ok && rsp_data == unique_tag_identifier[$past(req_word[1:0])*DATA_BITS +: DATA_BITS];
	endproperty
	a_uid_read: assert property (p_uid_read) else $error("identifier read wrong"); // [R3]

	property p_uid_fixed;
		@(posedge clock) disable iff (rst)
		take && req_op == OP_WRITE_UID |=> rsp_valid && !rsp_ok;
	endproperty
	a_uid_fixed: assert property (p_uid_fixed) else $error("identifier write accepted"); // [R4]

	property p_afc_write;
		@(posedge clock) disable iff (rst)
		take && req_op == OP_WRITE_AFC && !s.afc_locked
			|=> rsp_ok && s.afc == $past(req_data[CODE_BITS-1:0]);
	endproperty
	a_afc_write: assert property (p_afc_write) else $error("family code not written"); // [R5]

	property p_sfc_locked;
		@(posedge clock) disable iff (rst)
		take && req_op == OP_WRITE_SFC && s.sfc_locked |=> !rsp_ok && $stable(s.sfc);
	endproperty
	a_sfc_locked: assert property (p_sfc_locked) else $error("locked format code changed"); // [R5]

	property p_word_slice;
		@(posedge clock) disable iff (rst)
		mem_re |-> mem_addr[WORD_BITS-1:0] == req_word
			&& mem_addr[MEM_ADDR_BITS-1:WORD_BITS] == req_block;
	endproperty
	a_word_slice: assert property (p_word_slice) else $error("word slice misplaced"); // [R6]

endmodule // tag_area_policy
`default_nettype wire

/* File: verification/tag_host_model.sv */
// requesting host model that stands on the far side of the policy block
`timescale 1ns/100ps
`default_nettype none
module tag_host_model
	import tag_area_pkg::*;
(
	// clock
	input  wire logic                  clock,
	// request
	output var  logic                  req_valid,
	input  wire logic                  req_ready,
	output var  op_t                   req_op,
	output var  logic [BLOCK_BITS-1:0] req_block,
	output var  logic [WORD_BITS-1:0]  req_word,
	output var  logic [DATA_BITS-1:0]  req_data,
	// answer
	input  wire logic                  rsp_valid,
	input  wire logic                  rsp_ok,
	input  wire logic [DATA_BITS-1:0]  rsp_data
);
	// idle request lines from time zero
	initial begin
		req_valid = 1'b0;
		req_op    = OP_READ_WORD;
		req_block = 8'h00;
		req_word  = 4'h0;
		req_data  = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////
	// one request held until taken; system items only through their own ops
	task automatic issue(input op_t op, input logic [7:0] b, input logic [3:0] w,
			input logic [15:0] d, output logic [16:0] ans, output logic [16:0] tim);
		int   n;
		logic rdy;
		@(posedge clock);
		#1;
		req_valid = 1'b1;
		req_op    = op;
		req_block = b;
		req_word  = w;
		req_data  = d;
		n = 0;
		while (!req_ready && n < 8) begin
			@(posedge clock);
			#1;
			n++;
		end
		@(posedge clock);
		#1;
		req_valid = 1'b0;
		// released lines show the inverse so a stale value cannot pass
		req_block = ~b;
		req_word  = ~w;
		req_data  = ~d;
		// ready seen just after the take: low only in a read's wait cycle
		rdy = req_ready;
		n = 0;
		while (!rsp_valid && n < 4) begin
			@(posedge clock);
			#1;
			n++;
		end
		ans = rsp_valid ? {rsp_ok, rsp_data} : 17'bx;
		// ready after take in bit 3, cycles waited for the answer below it
		tim = {13'h0000, rdy, n[2:0]};
	endtask
endmodule // tag_host_model
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the tag area policy block
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import tag_area_pkg::*;
;
	logic                  clock = 1'b0;
	logic                  rst;
	logic                  req_valid;
	logic                  req_ready;
	op_t                   req_op;
	logic [BLOCK_BITS-1:0] req_block;
	logic [WORD_BITS-1:0]  req_word;
	logic [DATA_BITS-1:0]  req_data;
	logic                  rsp_valid;
	logic                  rsp_ok;
	logic [DATA_BITS-1:0]  rsp_data;
	// reference state of the tag
	logic [15:0]           mem [4096];
	bit                    wr [4096];
	bit                    blk_lk [256];
	logic [7:0]            afc;
	logic [7:0]            sfc;
	bit                    afc_lk;
	bit                    sfc_lk;
	int                    n_mismatch = 0;
	int                    n_checks = 0;
	logic [31:0]           seed;

	always #10 clock = ~clock;

	tag_area_policy u_dut (.clock(clock), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_block(req_block), .req_word(req_word),
		.req_data(req_data), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_data(rsp_data));
	tag_host_model u_host (.clock(clock), .req_valid(req_valid), .req_ready(req_ready),
		.req_op(req_op), .req_block(req_block), .req_word(req_word), .req_data(req_data),
		.rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_data(rsp_data));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// expected {ok, data}; also advances the reference state
	function automatic logic [16:0] predict(op_t op, logic [7:0] b, logic [3:0] w,
			logic [15:0] d);
		case (op)
			OP_READ_WORD: return {1'b1, mem[{b, w}]};
			OP_WRITE_WORD: begin
				if (blk_lk[b]) return 17'h0_0000;
				mem[{b, w}] = d;
				wr[{b, w}] = 1'b1;
				return 17'h1_0000;
			end
			OP_LOCK_BLOCK: begin
				blk_lk[b] = 1'b1;
				return 17'h1_0000;
			end
			OP_READ_SYSTEM: begin
				if (w <= SYS_UID_W3) return {1'b1, UID_VALUE[16*w +: 16]};
				if (w == SYS_AFC) return {9'h100, afc};
				if (w == SYS_SFC) return {9'h100, sfc};
				if (w == SYS_BLOCK_LOCK) return {16'h8000, blk_lk[b]};
				if (w == SYS_CODE_LOCKS) return {15'h4000, sfc_lk, afc_lk};
				return 17'h0_0000;
			end
			OP_WRITE_AFC: begin
				if (afc_lk) return 17'h0_0000;
				afc = d[7:0];
				return 17'h1_0000;
			end
			OP_WRITE_SFC: begin
				if (sfc_lk) return 17'h0_0000;
				sfc = d[7:0];
				return 17'h1_0000;
			end
			OP_LOCK_AFC: begin
				afc_lk = 1'b1;
				return 17'h1_0000;
			end
			OP_LOCK_SFC: begin
				sfc_lk = 1'b1;
				return 17'h1_0000;
			end
			default: return 17'h0_0000;
		endcase
	endfunction

	task automatic check(input string name, input logic [16:0] seen, input logic [16:0] want);
		n_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, want, seen);
		end
	endtask

	// unwritten store words read unknown, so their answers are not judged
	task automatic step(input op_t op, input logic [7:0] b, input logic [3:0] w,
			input logic [15:0] d);
		logic [16:0] seen;
		logic [16:0] want;
		logic [16:0] tim;
		logic [16:0] want_tim;
		bit          known;
		known = (op != OP_READ_WORD) || wr[{b, w}];
		want = predict(op, b, w, d);
		// a read answers one cycle late with ready low meanwhile, others at once
		want_tim = (op == OP_READ_WORD) ? 17'h0_0001 : 17'h0_0008;
		u_host.issue(op, b, w, d, seen, tim);
		if (known) check("answer", seen, want);
		check("timing", tim, want_tim);
	endtask

	// reset clears codes and locks but keeps the store
	task automatic apply_reset();
		rst = 1'b1;
		afc = 8'h00;
		sfc = 8'h00;
		afc_lk = 1'b0;
		sfc_lk = 1'b0;
		foreach (blk_lk[i]) blk_lk[i] = 1'b0;
		repeat (4) @(posedge clock);
		#1;
		rst = 1'b0;
	endtask

	task automatic conclude();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// corner cases first, then random traffic over every op code
	initial begin
		seed = 32'h02e2_7bac;
		apply_reset();
		step(OP_WRITE_WORD, 8'hFF, 4'hF, 16'hA5C3);
		step(OP_READ_WORD, 8'hFF, 4'hF, 16'h0000);
		step(OP_WRITE_WORD, 8'h5A, 4'h1, 16'h0001);
		step(OP_WRITE_WORD, 8'h5A, 4'h2, 16'h0002);
		step(OP_READ_WORD, 8'h5A, 4'h1, 16'h0000);
		step(OP_READ_WORD, 8'h5A, 4'h2, 16'h0000);
		step(OP_WRITE_WORD, 8'h00, 4'h0, 16'h1234);
		step(OP_LOCK_BLOCK, 8'h00, 4'h0, 16'h0000);
		step(OP_WRITE_WORD, 8'h00, 4'h0, 16'hFFFF);
		step(OP_READ_WORD, 8'h00, 4'h0, 16'h0000);
		step(OP_WRITE_UID, 8'h00, 4'h0, 16'hBEEF);
		step(OP_WRITE_AFC, 8'h00, 4'h0, 16'h005A);
		step(OP_LOCK_AFC, 8'h00, 4'h0, 16'h0000);
		step(OP_WRITE_AFC, 8'h00, 4'h0, 16'h00C3);
		for (int w = 0; w < 16; w++) step(OP_READ_SYSTEM, 8'h00, w[3:0], 16'h0000);
		repeat (300) begin
			seed = xorshift(seed);
			step(op_t'(seed[3:0]), seed[5] ? seed[15:8] : {8{seed[4]}}, seed[19:16],
				seed[31:16]);
		end
		apply_reset();
		for (int w = 4; w < 8; w++) step(OP_READ_SYSTEM, 8'h00, w[3:0], 16'h0000);
		step(OP_READ_WORD, 8'h00, 4'h0, 16'h0000);
		conclude();
	end

	// watchdog well beyond the expected run length
	initial begin
		#200000;
		n_mismatch++;
		conclude();
	end
endmodule // tb_top
`default_nettype wire
